// *** inc/ldo_regs_pkg.sv ***
// shared constants and types for the linear regulator control register bank
package ldo_regs_pkg;

    // register offsets on the serial control port
    localparam logic [7:0] ADDR_REG1_LEVEL = 8'h4c;
    localparam logic [7:0] ADDR_REG1_CTRL  = 8'h4d;
    localparam logic [7:0] ADDR_REG2_LEVEL = 8'h4f;
    localparam logic [7:0] ADDR_REG2_CTRL  = 8'h50;
    localparam logic [7:0] ADDR_REG3_LEVEL = 8'h52;
    localparam logic [7:0] ADDR_REG3_CTRL  = 8'h53;
    localparam logic [7:0] ADDR_PWR_CTRL0  = 8'h58;

    // control register field positions
    localparam int CTL_RUN_BIT    = 0;
    localparam int CTL_STBY_BIT   = 1;
    localparam int CTL_SLEEP_BIT  = 2;
    localparam int CTL_LPWR_BIT   = 3;
    localparam int CTL_SWITCH_BIT = 4;

    // power control field positions
    localparam int PWR_DLY_LSB    = 0;
    localparam int PWR_DLY_MSB    = 1;
    localparam int PWR_POL_BIT    = 2;

    // level field widths
    localparam int WIDE_LEVEL_W   = 5;
    localparam int NARROW_LEVEL_W = 4;
    localparam int NUM_REGS       = 3;

    // reset values
    localparam logic       CTL_BIT_RESET  = 1'b0;
    localparam logic [1:0] DLY_RESET      = 2'h1;
    localparam logic       POL_RESET      = 1'b0;
    localparam logic [1:0] DLY_CNT_RESET  = 2'h0;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    // one regulator's software-visible state
    typedef struct packed {
        logic [4:0] level;
        logic       switch_mode;
        logic       low_power;
        logic       sleep_en;
        logic       standby_en;
        logic       run_en;
    } reg_ctrl_s;

    // one regulator's resolved drive towards the analog side
    typedef struct packed {
        logic [4:0] level;
        logic       on;
        logic       low_power;
        logic       switch_mode;
    } reg_drive_s;

endpackage

// *** hw/ldo_ctrl_regs.sv ***
// linear regulator control register bank with standby input conditioning
//
// Function
// - regulators one and three have five-bit level in bits 4:0, seeded from fuses
// - regulator two has four-bit level in bits 3:0, upper bits unused
// - control bit 0 enables the regulator, loaded at power-up, software may clear
// - control bit 1 keeps the regulator on in standby, resets to zero
// - control bit 2 keeps the regulator on in sleep, resets to zero
// - control bit 3 selects low-power operation during standby and sleep
// - bit 4 of regulators one and three selects load-switch mode, seeded from fuses
// - load-switch mode may go from zero to one, never back to zero
// - power control bits 1:0 set extra standby delay, reset value 01
// - power control bit 2 sets standby input polarity, zero means active high
`timescale 1ns/1ns
module ldo_ctrl_regs
    import ldo_regs_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // byte-wide register port standing in for the serial host link
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // fuse seeds, taken once on the first edge after reset release
    input  wire logic [4:0]            fused_reg1_level,
    input  wire logic [3:0]            fused_reg2_level,
    input  wire logic [4:0]            fused_reg3_level,
    input  wire logic [2:0]            fused_run_enable,
    input  wire logic [1:0]            fused_switch_mode,
    // pins from outside this clock domain
    input  wire logic                  standby_pin,
    input  wire logic                  clk32k_pin,
    // sleep state from the power sequencer on this clock
    input  wire logic                  sleep_mode,
    // conditioned standby and per-regulator drive, all registered
    output logic                       standby_active,
    output reg_drive_s [NUM_REGS-1:0]  reg_drive
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    // every register runs on every edge; there is no clock gating here

    // regulator fields and the power control bits
    reg_ctrl_s [NUM_REGS-1:0] ctl_r;
    reg_ctrl_s [NUM_REGS-1:0] ctl_nxt;
    logic [1:0]               dly_code_r;
    logic [1:0]               dly_code_nxt;
    logic                     pol_r;
    logic                     pol_nxt;
    // low until the fuse seeds have been taken
    logic                     fuse_loaded_r;
    logic                     fuse_loaded_nxt;
    // read data, held between read strobes
    logic [7:0]               rdata_r;
    logic [7:0]               rdata_nxt;

    // level field readback; regulator two carries only four bits
    function automatic logic [7:0] level_view(input reg_ctrl_s c, input logic narrow);
        logic [7:0] v;
        v = {3'h0, c.level};
        if (narrow) begin
            v = {4'h0, c.level[NARROW_LEVEL_W-1:0]};
        end
        return v;
    endfunction

    // control field readback; regulator two has no switch mode bit
    function automatic logic [7:0] ctrl_view(input reg_ctrl_s c, input logic narrow);
        logic [7:0] v;
        v = {3'h0, c.switch_mode & ~narrow, c.low_power, c.sleep_en, c.standby_en, c.run_en};
        return v;
    endfunction

    // writes, and a one-shot fuse load on the first edge after reset release
    // a write in the load cycle is dropped, so hosts wait one edge after reset
    always_comb begin
        ctl_nxt         = ctl_r;
        dly_code_nxt    = dly_code_r;
        pol_nxt         = pol_r;
        fuse_loaded_nxt = 1'b1;
        // regulator two has no switch seed; its switch bit stays zero
        if (!fuse_loaded_r) begin
            ctl_nxt[0].level       = fused_reg1_level;
            ctl_nxt[1].level       = {1'b0, fused_reg2_level};
            ctl_nxt[2].level       = fused_reg3_level;
            ctl_nxt[0].run_en      = fused_run_enable[0];
            ctl_nxt[1].run_en      = fused_run_enable[1];
            ctl_nxt[2].run_en      = fused_run_enable[2];
            ctl_nxt[0].switch_mode = fused_switch_mode[0];
            ctl_nxt[2].switch_mode = fused_switch_mode[1];
        end else if (reg_wr) begin
            if (reg_addr == ADDR_REG1_LEVEL) begin
                ctl_nxt[0].level = reg_wdata[WIDE_LEVEL_W-1:0];
            end else if (reg_addr == ADDR_REG2_LEVEL) begin
                ctl_nxt[1].level = {1'b0, reg_wdata[NARROW_LEVEL_W-1:0]};
            end else if (reg_addr == ADDR_REG3_LEVEL) begin
                ctl_nxt[2].level = reg_wdata[WIDE_LEVEL_W-1:0];
            end else if (reg_addr == ADDR_REG1_CTRL) begin
                ctl_nxt[0].run_en      = reg_wdata[CTL_RUN_BIT];
                ctl_nxt[0].standby_en  = reg_wdata[CTL_STBY_BIT];
                ctl_nxt[0].sleep_en    = reg_wdata[CTL_SLEEP_BIT];
                ctl_nxt[0].low_power   = reg_wdata[CTL_LPWR_BIT];
                ctl_nxt[0].switch_mode = ctl_r[0].switch_mode | reg_wdata[CTL_SWITCH_BIT];
            end else if (reg_addr == ADDR_REG2_CTRL) begin
                ctl_nxt[1].run_en      = reg_wdata[CTL_RUN_BIT];
                ctl_nxt[1].standby_en  = reg_wdata[CTL_STBY_BIT];
                ctl_nxt[1].sleep_en    = reg_wdata[CTL_SLEEP_BIT];
                ctl_nxt[1].low_power   = reg_wdata[CTL_LPWR_BIT];
            end else if (reg_addr == ADDR_REG3_CTRL) begin
                ctl_nxt[2].run_en      = reg_wdata[CTL_RUN_BIT];
                ctl_nxt[2].standby_en  = reg_wdata[CTL_STBY_BIT];
                ctl_nxt[2].sleep_en    = reg_wdata[CTL_SLEEP_BIT];
                ctl_nxt[2].low_power   = reg_wdata[CTL_LPWR_BIT];
                ctl_nxt[2].switch_mode = ctl_r[2].switch_mode | reg_wdata[CTL_SWITCH_BIT];
            end else if (reg_addr == ADDR_PWR_CTRL0) begin
                dly_code_nxt = reg_wdata[PWR_DLY_MSB:PWR_DLY_LSB];
                pol_nxt      = reg_wdata[PWR_POL_BIT];
            end
        end
    end

    // readback mux; unmapped offsets read zero
    // a read in the same cycle as a write returns the value before it
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            if (reg_addr == ADDR_REG1_LEVEL) begin
                rdata_nxt = level_view(ctl_r[0], 1'b0);
            end else if (reg_addr == ADDR_REG2_LEVEL) begin
                rdata_nxt = level_view(ctl_r[1], 1'b1);
            end else if (reg_addr == ADDR_REG3_LEVEL) begin
                rdata_nxt = level_view(ctl_r[2], 1'b0);
            end else if (reg_addr == ADDR_REG1_CTRL) begin
                rdata_nxt = ctrl_view(ctl_r[0], 1'b0);
            end else if (reg_addr == ADDR_REG2_CTRL) begin
                rdata_nxt = ctrl_view(ctl_r[1], 1'b1);
            end else if (reg_addr == ADDR_REG3_CTRL) begin
                rdata_nxt = ctrl_view(ctl_r[2], 1'b0);
            end else if (reg_addr == ADDR_PWR_CTRL0) begin
                rdata_nxt = {5'h00, pol_r, dly_code_r};
            end else begin
                rdata_nxt = READ_ZERO;
            end
        end
    end

    // all control bits take zero at reset except the delay code, which takes 01; fuse seeds arrive one edge later
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctl_r         <= '0;
            dly_code_r    <= DLY_RESET;
            pol_r         <= POL_RESET;
            fuse_loaded_r <= 1'b0;
            rdata_r       <= READ_ZERO;
        end else begin
            ctl_r         <= ctl_nxt;
            dly_code_r    <= dly_code_nxt;
            pol_r         <= pol_nxt;
            fuse_loaded_r <= fuse_loaded_nxt;
            rdata_r       <= rdata_nxt;
        end
    end

    // read data stands until the next read strobe
    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a level counts once stages two and three agree
    // the slow clock is sampled as data, so its edges jitter by one ref cycle

    // three-stage samplers for the two outside pins
    logic [2:0] stby_sync_r;
    logic [2:0] stby_sync_nxt;
    logic [2:0] ck32_sync_r;
    logic [2:0] ck32_sync_nxt;
    // filtered levels and a one-cycle slow-clock strobe
    logic       stby_level_r;
    logic       stby_level_nxt;
    logic       ck32_level_r;
    logic       ck32_level_nxt;
    logic       tick32;

    // a pulse shorter than one ref cycle never changes the level
    always_comb begin
        stby_sync_nxt  = {stby_sync_r[1:0], standby_pin};
        ck32_sync_nxt  = {ck32_sync_r[1:0], clk32k_pin};
        stby_level_nxt = stby_level_r;
        ck32_level_nxt = ck32_level_r;
        if (stby_sync_r[1] == stby_sync_r[2]) begin
            stby_level_nxt = stby_sync_r[2];
        end
        if (ck32_sync_r[1] == ck32_sync_r[2]) begin
            ck32_level_nxt = ck32_sync_r[2];
        end
    end

    // a rising 32 kHz edge, seen once in the reference domain
    assign tick32 = ck32_level_nxt & ~ck32_level_r;

    // samplers start low; a pin already high after reset reads as a fresh change
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stby_sync_r  <= 3'h0;
            ck32_sync_r  <= 3'h0;
            stby_level_r <= 1'b0;
            ck32_level_r <= 1'b0;
        end else begin
            stby_sync_r  <= stby_sync_nxt;
            ck32_sync_r  <= ck32_sync_nxt;
            stby_level_r <= stby_level_nxt;
            ck32_level_r <= ck32_level_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // polarity and extra delay on the standby request
    // a request that returns before the delay ends is never passed on

    // request after polarity, the passed-on state and the tick count
    logic       stby_req;
    logic       stby_out_r;
    logic       stby_out_nxt;
    logic [1:0] dly_cnt_r;
    logic [1:0] dly_cnt_nxt;

    assign stby_req = stby_level_r ^ pol_r;

    // a change must persist for code ticks before it is passed on
    always_comb begin
        stby_out_nxt = stby_out_r;
        dly_cnt_nxt  = DLY_CNT_RESET;
        if (stby_req != stby_out_r) begin
            if (dly_code_r == 2'h0) begin
                stby_out_nxt = stby_req;
            end else if (tick32) begin
                if (dly_cnt_r + 2'h1 >= dly_code_r) begin
                    stby_out_nxt = stby_req;
                end else begin
                    dly_cnt_nxt = dly_cnt_r + 2'h1;
                end
            end else begin
                dly_cnt_nxt = dly_cnt_r;
            end
        end
    end

    // the count is zero whenever request and output agree, so a bounce restarts it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stby_out_r <= 1'b0;
            dly_cnt_r  <= DLY_CNT_RESET;
        end else begin
            stby_out_r <= stby_out_nxt;
            dly_cnt_r  <= dly_cnt_nxt;
        end
    end

    // with code zero the path costs one edge once the level has settled
    assign standby_active = stby_out_r;

    ////////////////////////////////////////////////////////////////////////
    // resolved drive per regulator, registered

    // one resolved drive word per regulator
    reg_drive_s [NUM_REGS-1:0] drive_r;
    reg_drive_s [NUM_REGS-1:0] drive_nxt;

    // sleep outranks standby; low power applies only in either low state
    // a regulator with its run bit clear stays off in every state
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_drive
            always_comb begin
                drive_nxt[i].level       = ctl_r[i].level;
                drive_nxt[i].switch_mode = ctl_r[i].switch_mode;
                drive_nxt[i].low_power   = ctl_r[i].low_power & (sleep_mode | stby_out_r);
                if (sleep_mode) begin
                    drive_nxt[i].on = ctl_r[i].run_en & ctl_r[i].sleep_en;
                end else if (stby_out_r) begin
                    drive_nxt[i].on = ctl_r[i].run_en & ctl_r[i].standby_en;
                end else begin
                    drive_nxt[i].on = ctl_r[i].run_en;
                end
            end
        end
    endgenerate

    // drive follows its register or mode input one edge later
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    // nothing reaches the analog side until reset is released
    assign reg_drive = drive_r;

endmodule

// *** verif/ldo_ctrl_regs_chk.sv ***
// concurrent checks on the regulator register bank ports
`timescale 1ns/1ns
module ldo_ctrl_regs_chk
    import ldo_regs_pkg::*;
(
    input wire logic                      ref_clk,
    input wire logic                      nrst,
    input wire logic [7:0]                reg_addr,
    input wire logic [7:0]                reg_wdata,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      sleep_mode,
    input wire logic                      standby_active,
    input wire reg_drive_s [NUM_REGS-1:0] reg_drive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // offsets that the bank decodes, and those with a five-bit payload
    logic mapped;
    logic wide_addr;
    assign mapped    = reg_addr inside {ADDR_REG1_LEVEL, ADDR_REG1_CTRL, ADDR_REG2_LEVEL, ADDR_REG2_CTRL,
                                        ADDR_REG3_LEVEL, ADDR_REG3_CTRL, ADDR_PWR_CTRL0};
    assign wide_addr = reg_addr inside {ADDR_REG1_LEVEL, ADDR_REG1_CTRL, ADDR_REG3_LEVEL, ADDR_REG3_CTRL};

    ////////////////////////////////////////////////////////////////////////////
    // read-back shape of unmapped offsets and of each register except regulator two control and power control
    unmapped_rd_a: assert property (reg_rd && !mapped |=> reg_rdata == READ_ZERO)
        else $error("unmapped read not zero");
    narrow_lvl_a: assert property (reg_rd && reg_addr == ADDR_REG2_LEVEL |=> reg_rdata[7:4] == 4'h0)
        else $error("narrow level upper bits set");
    wide_rd_a: assert property (reg_rd && wide_addr |=> reg_rdata[7:5] == 3'h0)
        else $error("unused bits set");
    ////////////////////////////////////////////////////////////////////////////
    // register values reaching the regulator drive, two edges after the write
    lvl_drive_a: assert property (reg_wr && reg_addr == ADDR_REG1_LEVEL |-> ##2
        reg_drive[0].level == 5'($past(reg_wdata, 2))) else $error("level not driven");
    narrow_drive_a: assert property (reg_wr && reg_addr == ADDR_REG2_LEVEL |-> ##2
        reg_drive[1].level == {1'b0, 4'($past(reg_wdata, 2))}) else $error("narrow level wrong");
    run_off_a: assert property ((reg_wr && reg_addr == ADDR_REG1_CTRL && !reg_wdata[CTL_RUN_BIT]
        && !sleep_mode && !standby_active) ##1 (!sleep_mode && !standby_active) |=> !reg_drive[0].on)
        else $error("run off ignored");
    // a load switch once engaged never drops back, only reset clears it
    switch_hold_a: assert property (!$fell(reg_drive[0].switch_mode)
        && !$fell(reg_drive[2].switch_mode)) else $error("switch mode cleared");
    low_pwr_a: assert property (reg_drive[2].low_power |->
        $past(sleep_mode) || $past(standby_active)) else $error("low power outside standby or sleep");

    cover property (reg_wr && reg_addr == ADDR_PWR_CTRL0);
    cover property ($rose(standby_active));
    cover property (sleep_mode && reg_drive[2].low_power);
endmodule

bind ldo_ctrl_regs ldo_ctrl_regs_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_mode(sleep_mode), .standby_active(standby_active), .reg_drive(reg_drive));

// *** verif/ldo_ctrl_regs_test.sv ***
// self-checking bench for the regulator register bank
`timescale 1ns/1ns
module ldo_ctrl_regs_test
    import ldo_regs_pkg::*;
;
    localparam logic [4:0] F1 = 5'h15;
    localparam logic [3:0] F2 = 4'ha;
    localparam logic [4:0] F3 = 5'h0b;
    // address, write data, expected read-back
    localparam logic [7:0] TA [10] = '{8'h4c, 8'h4c, 8'h4f, 8'h52, 8'h4d, 8'h50, 8'h53, 8'h4d, 8'h53, 8'h4e};
    localparam logic [7:0] TW [10] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff};
    localparam logic [7:0] TE [10] = '{8'h1f, 8'h00, 8'h0f, 8'h1f, 8'h1f, 8'h0f, 8'h1f, 8'h10, 8'h10, 8'h00};
    logic                      ref_clk = 1'b0;
    logic                      nrst = 1'b0;
    logic [7:0]                reg_addr = 8'h00;
    logic [7:0]                reg_wdata = 8'h00;
    logic                      reg_wr = 1'b0;
    logic                      reg_rd = 1'b0;
    logic                      standby_pin = 1'b0;
    logic                      clk32k_pin = 1'b0;
    logic                      sleep_mode = 1'b0;
    logic [7:0]                reg_rdata;
    logic                      standby_active;
    reg_drive_s [NUM_REGS-1:0] reg_drive;
    int                        n_fail = 0;
    int                        num_checks = 0;
    int                        cycles = 0;

    always #50 ref_clk = ~ref_clk;

    // fuse seeds tied: they are only sampled once after reset
    ldo_ctrl_regs u_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fused_reg1_level(F1),
        .fused_reg2_level(F2), .fused_reg3_level(F3), .fused_run_enable(3'h5), .fused_switch_mode(2'h1),
        .standby_pin(standby_pin), .clk32k_pin(clk32k_pin), .sleep_mode(sleep_mode),
        .standby_active(standby_active), .reg_drive(reg_drive));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the run should finish well inside this many cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("unexpected at %0t: run did not finish", $time);
            end_sim();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        step(1);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        step(1);
        {reg_addr, reg_rd} = {a, 1'b1};
        step(1);
        reg_rd = 1'b0;
        check(reg_rdata, exp);
    endtask

    // on, low power and switch flags of one regulator's drive
    task automatic drv(input int i, input logic [2:0] exp);
        check({5'h0, reg_drive[i].on, reg_drive[i].low_power, reg_drive[i].switch_mode}, {5'h0, exp});
    endtask

    // one slow-clock rising edge, stretched so the synchroniser sees it
    task automatic tick();
        clk32k_pin = 1'b1;
        step(5);
        clk32k_pin = 1'b0;
        step(5);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_seed();
        rd_chk(ADDR_REG1_LEVEL, {3'h0, F1});
        rd_chk(ADDR_REG1_CTRL, 8'h11);
        rd_chk(ADDR_REG2_LEVEL, {4'h0, F2});
        rd_chk(ADDR_REG2_CTRL, 8'h00);
        rd_chk(ADDR_REG3_LEVEL, {3'h0, F3});
        rd_chk(ADDR_REG3_CTRL, 8'h01);
        rd_chk(ADDR_PWR_CTRL0, {5'h00, POL_RESET, DLY_RESET});
        check({3'h0, reg_drive[0].level}, {3'h0, F1});
        check({3'h0, reg_drive[1].level}, {4'h0, F2});
        check({3'h0, reg_drive[2].level}, {3'h0, F3});
        drv(0, 3'b101);
        drv(1, 3'b000);
    endtask

    task automatic t_fields();
        for (int i = 0; i < 10; i++) begin
            wr(TA[i], TW[i]);
            rd_chk(TA[i], TE[i]);
        end
    endtask

    task automatic t_standby();
        wr(ADDR_REG1_CTRL, 8'h11);
        wr(ADDR_REG3_CTRL, 8'h1b);
        wr(ADDR_PWR_CTRL0, 8'h00);
        standby_pin = 1'b1;
        step(10);
        check({7'h0, standby_active}, 8'h01);
        drv(0, 3'b001);
        drv(2, 3'b111);
        wr(ADDR_PWR_CTRL0, 8'h04);
        step(10);
        check({7'h0, standby_active}, 8'h00);
        standby_pin = 1'b0;
        step(10);
        check({7'h0, standby_active}, 8'h01);
        // code 3: release waits for exactly three slow-clock edges, not ref edges
        wr(ADDR_PWR_CTRL0, 8'h07);
        standby_pin = 1'b1;
        step(20);
        check({7'h0, standby_active}, 8'h01);
        repeat (2) begin
            tick();
            check({7'h0, standby_active}, 8'h01);
        end
        tick();
        check({7'h0, standby_active}, 8'h00);
        wr(ADDR_PWR_CTRL0, 8'h00);
        standby_pin = 1'b0;
        step(10);
    endtask

    task automatic t_sleep();
        wr(ADDR_REG1_CTRL, 8'h15);
        wr(ADDR_REG2_CTRL, 8'h01);
        wr(ADDR_REG3_CTRL, 8'h1d);
        sleep_mode = 1'b1;
        step(5);
        drv(0, 3'b101);
        drv(1, 3'b000);
        drv(2, 3'b111);
        sleep_mode = 1'b0;
        step(5);
        drv(1, 3'b100);
        drv(2, 3'b101);
    endtask

    initial begin
        step(6);
        nrst = 1'b1;
        step(3);
        t_seed();
        t_fields();
        t_standby();
        t_sleep();
        end_sim();
    end
endmodule
